// >>> udi_defs.vh
// register map, field positions and reset values of the serial port data and irq registers
`ifndef UDI_DEFS_VH
`define UDI_DEFS_VH
`define UDI_ADDR_DATA      32'h4000_5000
`define UDI_ADDR_IRQ_EN    32'h4000_5004
`define UDI_ADDR_IRQ_ID    32'h4000_5008
`define UDI_ADDR_LINE_CTL  32'h4000_500c
`define UDI_ADDR_MODEM_CTL 32'h4000_5010
`define UDI_ADDR_LINE_FLG  32'h4000_5014
`define UDI_ADDR_MODEM_FLG 32'h4000_5018
`define UDI_ADDR_SCRATCH   32'h4000_501c
`define UDI_ADDR_FRAC_BAUD 32'h4000_5024
`define UDI_ADDR_BAUD_DIV  32'h4000_5028
`define UDI_RST_ZERO       16'h0000
`define UDI_RST_IRQ_ID     16'h0001
`define UDI_RST_BAUD_DIV   16'h0001
`define UDI_IEN_RX_FULL    0
`define UDI_IEN_TX_EMPTY   1
`define UDI_IEN_RX_LINE    2
`define UDI_IEN_MODEM      3
`define UDI_IEN_TX_DMA     4
`define UDI_IEN_RX_DMA     5
`define UDI_IEN_MASK       16'h003f
`define UDI_CAUSE_MODEM    2'b00
`define UDI_CAUSE_TX_EMPTY 2'b01
`define UDI_CAUSE_RX_FULL  2'b10
`define UDI_CAUSE_RX_LINE  2'b11
`define UDI_LSR_BREAK      4
`define UDI_RESP_OKAY      2'b00
`define UDI_RESP_SLVERR    2'b10
`endif

// >>> udi_regs.v
// serial port data, irq enable and irq identification registers behind an axi4-lite slave
//
// The AXI4-Lite slave port was decided locally.
`include "udi_defs.vh"
// Summary of operation
// [R1] one address: write loads tx, read returns rx
// [R2] tx holds low byte; upper bits read zero
// [R3] tx-empty enable raises irq when holding empties
// [R4] enabling while already empty interrupts at once
// [R5] rx-full enable raises irq on loaded character
// [R6] enabling while rx already full interrupts at once
// [R7] enable bit 5 gates rx dma request
// [R8] enable bit 4 gates tx dma request
// [R9] bits 3:0 gate irq sources; 15:6 zero
// [R10] modem irq when any modem change flag set
// [R11] ident bit 0 low means irq pending
// [R12] ident bits 2:1 encode the pending cause
// [R13] modem flags read clears modem irq
// [R14] tx write, or ident read reporting tx-empty, clears tx-empty irq
// [R15] rx buffer read clears rx-full irq
// [R16] line flags read clears line irq
// [R17] reset: ident 0x0001, all enables zero
// [R18] one irq output for every cause
// [R19] no break cause while dma is enabled
// [R20] overwrite and re-read go undetected
// [R21] priority: line, rx full, tx empty, modem
module udi_regs (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        rx_char_valid,
   input  wire [7:0]  rx_char_data,
   input  wire        tx_load,
   input  wire        tx_shift_empty,
   input  wire [3:0]  line_err_set,
   input  wire [3:0]  modem_delta_set,
   input  wire [3:0]  modem_level,
   output wire [7:0]  tx_hold_byte,
   output wire        tx_hold_full,
   output wire [15:0] line_control,
   output wire [15:0] modem_control,
   output wire [15:0] fractional_baud,
   output wire [15:0] baud_divisor,
   output wire        irq,
   output wire        rx_dma_req,
   output wire        tx_dma_req
);
   reg  [31:0] aw_addr_r;
   reg         aw_got_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   reg         w_got_r;
   reg  [7:0]  tx_byte_r;
   reg         tx_full_r;
   reg         tx_empty_d_r;
   reg         tx_pend_r;
   reg  [7:0]  rx_byte_r;
   reg         rx_full_r;
   reg  [15:0] ien_r;
   reg  [15:0] lcr_r;
   reg  [15:0] mcr_r;
   reg  [15:0] scr_r;
   reg  [15:0] fbr_r;
   reg  [15:0] div_r;
   reg  [3:0]  lerr_r;
   reg  [3:0]  mdelta_r;
   reg  [31:0] rdata_nxt;
   reg  [1:0]  rresp_nxt;
   reg  [15:0] ien_nxt;
   reg  [1:0]  cause;
   wire        aw_hs;
   wire        w_hs;
   wire        ar_hs;
   wire        do_wr;
   wire [31:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire        wr_hit;
   wire        rd_hit;
   wire        wr_data_reg;
   wire        wr_ien;
   wire        rd_data_reg;
   wire        rd_ident;
   wire        rd_lflags;
   wire        rd_mflags;
   wire        tx_empty;
   wire        dma_mode;
   wire [3:0]  lerr_irq;
   wire        src_line;
   wire        src_rx;
   wire        src_tx;
   wire        src_modem;
   wire        any_src;
   wire [15:0] ident;
   wire [15:0] lsr;
   wire [15:0] msr;

   // handshake outputs are combinational; each channel is taken once per write
   assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs  = s_axi_wvalid & s_axi_wready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign do_wr = (aw_got_r | aw_hs) & (w_got_r | w_hs);
   assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
   assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
   assign wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;

   // the shared address: writes land in tx holding, reads come from rx buffer
   assign wr_data_reg = do_wr & (wr_addr == `UDI_ADDR_DATA) & wr_strb[0]; // [R1]
   assign wr_ien      = do_wr & (wr_addr == `UDI_ADDR_IRQ_EN);
   assign rd_data_reg = ar_hs & (s_axi_araddr == `UDI_ADDR_DATA); // [R1]
   assign rd_ident    = ar_hs & (s_axi_araddr == `UDI_ADDR_IRQ_ID);
   assign rd_lflags   = ar_hs & (s_axi_araddr == `UDI_ADDR_LINE_FLG);
   assign rd_mflags   = ar_hs & (s_axi_araddr == `UDI_ADDR_MODEM_FLG);

   assign wr_hit = (wr_addr == `UDI_ADDR_DATA) | (wr_addr == `UDI_ADDR_IRQ_EN) |
                   (wr_addr == `UDI_ADDR_LINE_CTL) | (wr_addr == `UDI_ADDR_MODEM_CTL) |
                   (wr_addr == `UDI_ADDR_SCRATCH) | (wr_addr == `UDI_ADDR_FRAC_BAUD) |
                   (wr_addr == `UDI_ADDR_BAUD_DIV);
   assign rd_hit = (s_axi_araddr == `UDI_ADDR_DATA) | (s_axi_araddr == `UDI_ADDR_IRQ_EN) |
                   (s_axi_araddr == `UDI_ADDR_IRQ_ID) |
                   (s_axi_araddr == `UDI_ADDR_LINE_CTL) |
                   (s_axi_araddr == `UDI_ADDR_MODEM_CTL) |
                   (s_axi_araddr == `UDI_ADDR_LINE_FLG) |
                   (s_axi_araddr == `UDI_ADDR_MODEM_FLG) |
                   (s_axi_araddr == `UDI_ADDR_SCRATCH) |
                   (s_axi_araddr == `UDI_ADDR_FRAC_BAUD) |
                   (s_axi_araddr == `UDI_ADDR_BAUD_DIV);

   assign tx_empty = ~tx_full_r;
   assign dma_mode = ien_r[`UDI_IEN_RX_DMA] | ien_r[`UDI_IEN_TX_DMA];
   // break flag stays visible in the line flags but cannot interrupt under dma
   assign lerr_irq = dma_mode ? (lerr_r & 4'b0111) : lerr_r; // [R19]

   // the low four enable bits gate the interrupt sources; bits 5:4 reach the line source only through the break mask
   assign src_line  = ien_r[`UDI_IEN_RX_LINE] & (|lerr_irq); // [R9]
   assign src_rx    = ien_r[`UDI_IEN_RX_FULL] & rx_full_r; // [R5] [R6]
   assign src_tx    = ien_r[`UDI_IEN_TX_EMPTY] & tx_pend_r; // [R3]
   assign src_modem = ien_r[`UDI_IEN_MODEM] & (|mdelta_r); // [R10]
   assign any_src   = src_line | src_rx | src_tx | src_modem;

   always @* begin
      if (src_line) begin // [R21]
         cause = `UDI_CAUSE_RX_LINE;
      end else if (src_rx) begin
         cause = `UDI_CAUSE_RX_FULL;
      end else if (src_tx) begin
         cause = `UDI_CAUSE_TX_EMPTY;
      end else begin
         cause = `UDI_CAUSE_MODEM;
      end
   end

   // cause bits read zero while nothing is pending
   assign ident = {13'h0000, any_src ? cause : 2'b00, ~any_src}; // [R11] [R12]
   assign irq   = any_src; // [R18]

   assign rx_dma_req = ien_r[`UDI_IEN_RX_DMA] & rx_full_r; // [R7]
   assign tx_dma_req = ien_r[`UDI_IEN_TX_DMA] & tx_empty; // [R8]

   // line flags: data ready, four error flags, holding empty, shifter empty
   assign lsr = {9'h000, tx_shift_empty & tx_empty, tx_empty, lerr_r, rx_full_r};
   assign msr = {8'h00, modem_level, mdelta_r};

   assign tx_hold_byte    = tx_byte_r;
   assign tx_hold_full    = tx_full_r;
   assign line_control    = lcr_r;
   assign modem_control   = mcr_r;
   assign fractional_baud = fbr_r;
   assign baud_divisor    = div_r;

   always @* begin
      ien_nxt = ien_r;
      if (wr_strb[0]) begin
         ien_nxt[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
         ien_nxt[15:8] = wr_data[15:8];
      end
      ien_nxt = ien_nxt & `UDI_IEN_MASK; // [R9]
   end

   always @* begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = `UDI_RESP_OKAY;
      case (s_axi_araddr)
         `UDI_ADDR_DATA:      rdata_nxt = {24'h00_0000, rx_byte_r}; // [R2] [R20]
         `UDI_ADDR_IRQ_EN:    rdata_nxt = {16'h0000, ien_r};
         `UDI_ADDR_IRQ_ID:    rdata_nxt = {16'h0000, ident};
         `UDI_ADDR_LINE_CTL:  rdata_nxt = {16'h0000, lcr_r};
         `UDI_ADDR_MODEM_CTL: rdata_nxt = {16'h0000, mcr_r};
         `UDI_ADDR_LINE_FLG:  rdata_nxt = {16'h0000, lsr};
         `UDI_ADDR_MODEM_FLG: rdata_nxt = {16'h0000, msr};
         `UDI_ADDR_SCRATCH:   rdata_nxt = {16'h0000, scr_r};
         `UDI_ADDR_FRAC_BAUD: rdata_nxt = {16'h0000, fbr_r};
         `UDI_ADDR_BAUD_DIV:  rdata_nxt = {16'h0000, div_r};
         default:             rresp_nxt = `UDI_RESP_SLVERR;
      endcase
   end

   // bus channel capture and responses
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_r    <= 32'h0000_0000;
         aw_got_r     <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         w_got_r      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `UDI_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `UDI_RESP_OKAY;
      end else begin
         if (do_wr) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `UDI_RESP_OKAY : `UDI_RESP_SLVERR;
         end else begin
            if (aw_hs) begin
               aw_addr_r <= s_axi_awaddr;
               aw_got_r  <= 1'b1;
            end
            if (w_hs) begin
               w_data_r <= s_axi_wdata;
               w_strb_r <= s_axi_wstrb;
               w_got_r  <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
         if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_nxt;
            s_axi_rresp  <= rd_hit ? `UDI_RESP_OKAY : `UDI_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // irq enable, scratch, and plain storage registers handed to the shifter and baud logic
   always @(posedge aclk) begin
      if (!aresetn) begin
         ien_r <= `UDI_RST_ZERO; // [R17]
         lcr_r <= `UDI_RST_ZERO;
         mcr_r <= `UDI_RST_ZERO;
         scr_r <= `UDI_RST_ZERO;
         fbr_r <= `UDI_RST_ZERO;
         div_r <= `UDI_RST_BAUD_DIV;
      end else if (do_wr) begin
         if (wr_ien) begin
            ien_r <= ien_nxt;
         end
         if (wr_addr == `UDI_ADDR_LINE_CTL) begin
            lcr_r <= {wr_strb[1] ? wr_data[15:8] : lcr_r[15:8],
                      wr_strb[0] ? wr_data[7:0] : lcr_r[7:0]};
         end
         if (wr_addr == `UDI_ADDR_MODEM_CTL) begin
            mcr_r <= {wr_strb[1] ? wr_data[15:8] : mcr_r[15:8],
                      wr_strb[0] ? wr_data[7:0] : mcr_r[7:0]};
         end
         if (wr_addr == `UDI_ADDR_SCRATCH) begin
            scr_r <= {wr_strb[1] ? wr_data[15:8] : scr_r[15:8],
                      wr_strb[0] ? wr_data[7:0] : scr_r[7:0]};
         end
         if (wr_addr == `UDI_ADDR_FRAC_BAUD) begin
            fbr_r <= {wr_strb[1] ? wr_data[15:8] : fbr_r[15:8],
                      wr_strb[0] ? wr_data[7:0] : fbr_r[7:0]};
         end
         if (wr_addr == `UDI_ADDR_BAUD_DIV) begin
            div_r <= {wr_strb[1] ? wr_data[15:8] : div_r[15:8],
                      wr_strb[0] ? wr_data[7:0] : div_r[7:0]};
         end
      end
   end

   // transmit holding: a write while full silently replaces the byte
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_byte_r    <= 8'h00;
         tx_full_r    <= 1'b0;
         tx_empty_d_r <= 1'b1;
         tx_pend_r    <= 1'b0;
      end else begin
         tx_empty_d_r <= tx_empty;
         if (wr_data_reg) begin
            tx_byte_r <= wr_data[7:0]; // [R2] [R20]
            tx_full_r <= 1'b1;
         end else if (tx_load) begin
            tx_full_r <= 1'b0;
         end
         // a fresh empty edge, or enabling while empty, wins over any clear
         if ((tx_empty && !tx_empty_d_r) ||
             (wr_ien && ien_nxt[`UDI_IEN_TX_EMPTY] &&
              !ien_r[`UDI_IEN_TX_EMPTY] && tx_empty)) begin // [R3] [R4]
            tx_pend_r <= 1'b1;
         end else if (wr_data_reg ||
                      (rd_ident && any_src && cause == `UDI_CAUSE_TX_EMPTY)) begin
            tx_pend_r <= 1'b0; // [R14]
         end
      end
   end

   // receive buffer: a read of an old byte returns it again
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_byte_r <= 8'h00;
         rx_full_r <= 1'b0;
      end else if (rx_char_valid) begin
         rx_byte_r <= rx_char_data; // [R5]
         rx_full_r <= 1'b1;
      end else if (rd_data_reg) begin
         rx_full_r <= 1'b0; // [R15]
      end
   end

   // sticky line and modem flags; a new event in the clearing read survives
   always @(posedge aclk) begin
      if (!aresetn) begin
         lerr_r   <= 4'h0;
         mdelta_r <= 4'h0;
      end else begin
         lerr_r   <= (rd_lflags ? 4'h0 : lerr_r) | line_err_set; // [R16]
         mdelta_r <= (rd_mflags ? 4'h0 : mdelta_r) | modem_delta_set; // [R13]
      end
   end
endmodule // udi_regs

// >>> udi_regs_monitor.sv
// assertion checker for the serial port data and irq registers
`include "udi_defs.vh"
module udi_regs_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        rx_char_valid,
   input wire logic [7:0]  tx_hold_byte,
   input wire logic        tx_hold_full,
   input wire logic        irq,
   input wire logic        rx_dma_req,
   input wire logic        tx_dma_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rd_addr_r;
   wire         wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire         rd_go = s_axi_arvalid && s_axi_arready;
   // remembers which register the pending read answer belongs to
   always_ff @(posedge aclk) begin
      if (rd_go) begin
         rd_addr_r <= s_axi_araddr;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !rx_dma_req && !tx_dma_req)
      else $error("outputs active right after reset");
   a_tx_load_byte: assert property (wr_go && s_axi_awaddr == `UDI_ADDR_DATA && s_axi_wstrb[0]
      |=> tx_hold_full && tx_hold_byte == $past(s_axi_wdata[7:0]))
      else $error("holding byte not loaded by data write");
   a_data_upper_zero: assert property (s_axi_rvalid && rd_addr_r == `UDI_ADDR_DATA
      |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("data read upper bits not zero");
   a_ien_reserved: assert property (s_axi_rvalid && rd_addr_r == `UDI_ADDR_IRQ_EN
      |-> s_axi_rdata[31:6] == 26'h000_0000) else $error("enable reserved bits not zero");
   a_ident_flag: assert property (rd_go && s_axi_araddr == `UDI_ADDR_IRQ_ID
      |=> s_axi_rdata[0] == !$past(irq)) else $error("pending flag disagrees with irq");
   a_ident_idle: assert property (s_axi_rvalid && rd_addr_r == `UDI_ADDR_IRQ_ID
      && s_axi_rdata[0] |-> s_axi_rdata[2:1] == 2'b00) else $error("cause bits set while idle");
   a_rx_read_drop: assert property (rd_go && s_axi_araddr == `UDI_ADDR_DATA && !rx_char_valid
      |=> !rx_dma_req) else $error("rx dma request survives buffer read");
   a_tx_dma_empty: assert property (tx_dma_req |-> !tx_hold_full)
      else $error("tx dma request while holding full");
   c_irq_drop: cover property (irq ##1 !irq);
   c_rx_dma: cover property (rx_dma_req);
   c_tx_dma_irq: cover property (tx_dma_req && irq);
endmodule // udi_regs_monitor
bind udi_regs udi_regs_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .rx_char_valid(rx_char_valid), .tx_hold_byte(tx_hold_byte), .tx_hold_full(tx_hold_full),
   .irq(irq), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));

// >>> udi_far_model.sv
// model of the serial shifter and receiver facing the register block
module udi_far_model (
   input  wire logic       aclk,
   output logic            rx_char_valid,
   output logic [7:0]      rx_char_data,
   output logic            tx_load,
   output logic            tx_shift_empty,
   output logic [3:0]      line_err_set,
   output logic [3:0]      modem_delta_set,
   output logic [3:0]      modem_level
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_char_valid = 1'b0;
      rx_char_data = 8'h00;
      tx_load = 1'b0;
      tx_shift_empty = 1'b1;
      line_err_set = 4'h0;
      modem_delta_set = 4'h0;
      modem_level = 4'ha;
   end
   // a whole character arrives in one pulse; data then turns stale on purpose
   task send_rx(input logic [7:0] d);
      @(posedge aclk);
      rx_char_valid <= 1'b1;
      rx_char_data <= d;
      @(posedge aclk);
      rx_char_valid <= 1'b0;
      rx_char_data <= ~d;
   endtask
   task flag_pulse(input logic [3:0] err, input logic [3:0] mdm);
      @(posedge aclk);
      line_err_set <= err;
      modem_delta_set <= mdm;
      @(posedge aclk);
      line_err_set <= 4'h0;
      modem_delta_set <= 4'h0;
   endtask
   // shifter takes the byte and stays busy for a while, as a slow line would
   task take_tx();
      @(posedge aclk);
      tx_load <= 1'b1;
      tx_shift_empty <= 1'b0;
      @(posedge aclk);
      tx_load <= 1'b0;
      repeat (10) @(posedge aclk);
      tx_shift_empty <= 1'b1;
   endtask
endmodule // udi_far_model

// >>> udi_regs_test.sv
// self-checking bench for the serial port data and irq registers
`include "udi_defs.vh"
module udi_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, rxv, txl, txe, irq, rxd, txd, full;
   logic [1:0] bresp, rresp, r;
   logic [7:0] rxb, txb;
   logic [3:0] les, mds, mlv;
   logic [15:0] lco, mco, fbo, dvo;
   int fail_count = 0, n_compared = 0;
   udi_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_char_valid(rxv),
      .rx_char_data(rxb), .tx_load(txl), .tx_shift_empty(txe), .line_err_set(les),
      .modem_delta_set(mds), .modem_level(mlv), .tx_hold_byte(txb), .tx_hold_full(full),
      .line_control(lco), .modem_control(mco), .fractional_baud(fbo), .baud_divisor(dvo),
      .irq(irq),
      .rx_dma_req(rxd), .tx_dma_req(txd));
   udi_far_model far (.aclk(aclk), .rx_char_valid(rxv), .rx_char_data(rxb), .tx_load(txl),
      .tx_shift_empty(txe), .line_err_set(les), .modem_delta_set(mds), .modem_level(mlv));
   initial begin
      forever #20 aclk = ~aclk;
   end
   task complete_run();
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // both channels offered together, each dropped once taken
   task wr(input logic [31:0] a, input logic [31:0] v);
      logic ad, dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awvalid && awready) begin ad = 1; awvalid <= 0; end
         if (wvalid && wready) begin dd = 1; wvalid <= 0; end
      end
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 0;
   endtask
   task rd(input logic [31:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task rc(input logic [31:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
   endtask
   // let the edge's updates land before looking at the pins
   task pins(input logic [2:0] exp);
      #1;
      chk({29'h0, irq, rxd, txd}, {29'h0, exp});
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0001);
      rc(`UDI_ADDR_IRQ_EN, 32'h0000_0000);
      rc(`UDI_ADDR_LINE_FLG, 32'h0000_0060);
      chk({lco, dvo}, 32'h0000_0001);
      chk({mco, fbo}, 32'h0000_0000);
      wr(`UDI_ADDR_IRQ_EN, 32'h0000_ffff);
      rc(`UDI_ADDR_IRQ_EN, 32'h0000_003f);
      pins(3'b101);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0002);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0001);
      far.send_rx(8'ha5);
      pins(3'b111);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0004);
      rc(`UDI_ADDR_DATA, 32'h0000_00a5);
      pins(3'b001);
      rc(`UDI_ADDR_DATA, 32'h0000_00a5);
      far.flag_pulse(4'h1, 4'h0);
      far.send_rx(8'h3c);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0006);
      rc(`UDI_ADDR_LINE_FLG, 32'h0000_0063);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0004);
      rc(`UDI_ADDR_DATA, 32'h0000_003c);
      far.flag_pulse(4'h0, 4'h4);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0000);
      rc(`UDI_ADDR_MODEM_FLG, 32'h0000_00a4);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0001);
      wr(`UDI_ADDR_DATA, 32'h0000_1234);
      pins(3'b000);
      chk({23'h0, full, txb}, 32'h0000_0134);
      wr(`UDI_ADDR_DATA, 32'h0000_0056);
      chk({23'h0, full, txb}, 32'h0000_0156);
      far.take_tx();
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0002);
      wr(`UDI_ADDR_DATA, 32'h0000_0077);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0001);
      far.flag_pulse(4'h8, 4'h0);
      rc(`UDI_ADDR_IRQ_ID, 32'h0000_0001);
      rc(`UDI_ADDR_LINE_FLG, 32'h0000_0010);
      wr(`UDI_ADDR_IRQ_EN, 32'h0000_0000);
      far.send_rx(8'h81);
      pins(3'b000);
      wr(`UDI_ADDR_IRQ_EN, 32'h0000_0001);
      pins(3'b100);
      rc(`UDI_ADDR_DATA, 32'h0000_0081);
      rd(32'h4000_5020);
      chk({30'h0, r}, {30'h0, `UDI_RESP_SLVERR});
      wr(32'h4000_5020, 32'h0000_00ff);
      chk({30'h0, r}, {30'h0, `UDI_RESP_SLVERR});
      wr(`UDI_ADDR_LINE_CTL, 32'h0000_005a);
      chk({30'h0, r}, {30'h0, `UDI_RESP_OKAY});
      chk({lco, mco}, 32'h005a_0000);
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      complete_run();
   end
endmodule // udi_regs_test
